// ==== pin_mode_pkg.sv ====
package pin_mode_pkg;

    // Register addresses in the register page
    localparam logic [7:0] ADDR_P2_LOW  = 8'hE9;
    localparam logic [7:0] ADDR_P3_HIGH = 8'hEA;
    localparam logic [7:0] ADDR_P3_LOW  = 8'hEB;

    // Reset values
    localparam logic [7:0] RESET_CONFIG = 8'h00;

    // Implemented bits of the port 3 high register
    localparam logic [7:0] P3_HIGH_MASK = 8'h3F;

    // Route select bits in the port 3 high register
    localparam int SEL_P31_BIT = 5;
    localparam int SEL_P30_BIT = 4;

    // Field width of one pin mode
    localparam int FIELD_W = 2;

    // Pin mode codes
    typedef enum logic [1:0]
    {
        MODE_INPUT  = 2'h0,
        MODE_PULLUP = 2'h1,
        MODE_PUSH   = 2'h2,
        MODE_ALT    = 2'h3
    } pin_mode_e;

endpackage : pin_mode_pkg

// ==== pin_field_decode.sv ====
`timescale 1ns/10ps
// Decodes one 2-bit pin mode field into pad controls
module pin_field_decode
(
    // Field and sources
    input  wire logic [1:0] mode_in,
    input  wire logic       port_data_in,
    input  wire logic       alt_data_in,
    // Pad controls
    output logic            drive_en_out,
    output logic            drive_val_out,
    output logic            pull_up_out,
    output logic            input_en_out
);

    // Mode decode wires
    wire is_push = (mode_in == pin_mode_pkg::MODE_PUSH);
    wire is_alt  = (mode_in == pin_mode_pkg::MODE_ALT);

    // Both output codes drive; alternative takes the peripheral value
    assign drive_en_out  = is_push | is_alt;
    assign drive_val_out = is_alt ? alt_data_in : port_data_in;
    assign pull_up_out   = (mode_in == pin_mode_pkg::MODE_PULLUP);
    assign input_en_out  = ~mode_in[1];

endmodule : pin_field_decode

// ==== port2_port3_pin_mode_mux.sv ====
`timescale 1ns/10ps
module port2_port3_pin_mode_mux
#(
    parameter int PINS = 10
)
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Register access port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic      [7:0] reg_rdata_out,
    // Port data latches from the core
    input  wire logic [3:0] port2_data_in,
    input  wire logic [5:0] port3_data_in,
    // Peripheral sources
    input  wire logic       timer_a_output_in,
    input  wire logic       timer_b_pwm_output_in,
    input  wire logic       lcd_segment_34_in,
    input  wire logic       lcd_segment_35_in,
    input  wire logic       lcd_segment_36_in,
    input  wire logic       lcd_segment_37_in,
    input  wire logic       serial_tx_in,
    input  wire logic       serial_rx_drive_in,
    // Pad input levels
    input  wire logic [3:0] port2_pad_in,
    input  wire logic [5:0] port3_pad_in,
    // Pad controls, pins p2.0-3 then p3.0-5
    output logic [PINS-1:0] pad_drive_en_out,
    output logic [PINS-1:0] pad_drive_val_out,
    output logic [PINS-1:0] pad_pull_up_out,
    // Peripheral inputs
    output logic [3:0]      analog_channel_en_out,
    output logic            timer_a_capture_in_out,
    output logic            serial_rx_out
);

    // Only ten pins are wired to the register fields
    if (PINS != 10)
    begin : g_bad_pins
        $error("PINS must be 10");
    end

    // Configuration registers
    logic [7:0] p2_low_q;
    logic [7:0] p3_high_q;
    logic [7:0] p3_low_q;

    // Write decode
    wire wr_p2l = reg_write_in && (reg_addr_in == pin_mode_pkg::ADDR_P2_LOW);
    wire wr_p3h = reg_write_in && (reg_addr_in == pin_mode_pkg::ADDR_P3_HIGH);
    wire wr_p3l = reg_write_in && (reg_addr_in == pin_mode_pkg::ADDR_P3_LOW);

    // Register storage, cleared at reset
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            p2_low_q  <= pin_mode_pkg::RESET_CONFIG;
            p3_high_q <= pin_mode_pkg::RESET_CONFIG;
            p3_low_q  <= pin_mode_pkg::RESET_CONFIG;
        end
        else
        begin
            if (wr_p2l)
                p2_low_q <= reg_wdata_in;
            if (wr_p3h)
                p3_high_q <= reg_wdata_in & pin_mode_pkg::P3_HIGH_MASK;
            if (wr_p3l)
                p3_low_q <= reg_wdata_in;
        end
    end

    // Read mux; unmapped reads return zero
    wire [7:0] rdata_d =
        (reg_addr_in == pin_mode_pkg::ADDR_P2_LOW)  ? p2_low_q  :
        (reg_addr_in == pin_mode_pkg::ADDR_P3_HIGH) ? p3_high_q :
        (reg_addr_in == pin_mode_pkg::ADDR_P3_LOW)  ? p3_low_q  :
        8'h00;

    // Read data registered so the output comes from a flop
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reg_rdata_out <= 8'h00;
        else if (reg_read_in)
            reg_rdata_out <= rdata_d;
    end

    // Per-pin fields: p2.0-3, p3.0-3 from low reg, p3.4-5 from high reg
    wire [2*PINS-1:0] fields = {p3_high_q[3:0], p3_low_q, p2_low_q};

    // Alternative-function sources; route selects for 3.0 and 3.1
    wire alt_p30 = p3_high_q[pin_mode_pkg::SEL_P30_BIT] ?
                   lcd_segment_34_in : timer_b_pwm_output_in;
    wire alt_p31 = p3_high_q[pin_mode_pkg::SEL_P31_BIT] ?
                   lcd_segment_35_in : timer_a_output_in;
    // Analog pins carry no digital drive value
    wire [PINS-1:0] alt_src = {serial_rx_drive_in, serial_tx_in,
                               lcd_segment_37_in, lcd_segment_36_in,
                               alt_p31, alt_p30, 4'h0};
    wire [PINS-1:0] port_src = {port3_data_in, port2_data_in};

    // Combinational pad controls from the decoders
    wire [PINS-1:0] drv_en_d;
    wire [PINS-1:0] drv_val_d;
    wire [PINS-1:0] pull_d;
    wire [PINS-1:0] in_en_d;

    // One decoder per pin
    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_pin
            pin_field_decode u_dec
            (
                .mode_in      (fields[2*g +: 2]),
                .port_data_in (port_src[g]),
                .alt_data_in  (alt_src[g]),
                .drive_en_out (drv_en_d[g]),
                .drive_val_out(drv_val_d[g]),
                .pull_up_out  (pull_d[g]),
                .input_en_out (in_en_d[g])
            );
        end
    endgenerate

    // Analog channels: port 2 alternative, drivers off
    wire [3:0] an_en_d;
    assign an_en_d[0] = (p2_low_q[1:0] == pin_mode_pkg::MODE_ALT);
    assign an_en_d[1] = (p2_low_q[3:2] == pin_mode_pkg::MODE_ALT);
    assign an_en_d[2] = (p2_low_q[5:4] == pin_mode_pkg::MODE_ALT);
    assign an_en_d[3] = (p2_low_q[7:6] == pin_mode_pkg::MODE_ALT);
    wire [PINS-1:0] drv_mask = {6'h3F, ~an_en_d};

    // Capture input when pin 3.3 is in either input mode
    wire cap_d = in_en_d[7] & port3_pad_in[3];
    // Receive input on pin 3.5 in its input modes, idle high otherwise
    wire rx_d  = in_en_d[9] ? port3_pad_in[5] : 1'b1;

    // Output registers
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pad_drive_en_out       <= '0;
            pad_drive_val_out      <= '0;
            pad_pull_up_out        <= '0;
            analog_channel_en_out  <= 4'h0;
            timer_a_capture_in_out <= 1'b0;
            serial_rx_out          <= 1'b1;
        end
        else
        begin
            pad_drive_en_out       <= drv_en_d & drv_mask;
            pad_drive_val_out      <= drv_val_d & drv_mask;
            pad_pull_up_out        <= pull_d;
            analog_channel_en_out  <= an_en_d;
            timer_a_capture_in_out <= cap_d;
            serial_rx_out          <= rx_d;
        end
    end

    // Pad inputs of port 2 are read by the core elsewhere
    wire unused_ok = ^port2_pad_in;

    // Assertions
    a_p3h_top_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        p3_high_q[7:6] == 2'h0) else $error("unused bits set");
    a_reg_write_read: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        wr_p2l ##1 (reg_read_in && reg_addr_in == pin_mode_pkg::ADDR_P2_LOW
        && !reg_write_in) |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("write not read back");
    a_p31_segment: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (p3_low_q[3:2] == 2'h3 && p3_high_q[5] && lcd_segment_35_in)
        |=> pad_drive_en_out[5] && pad_drive_val_out[5])
        else $error("pin 3.1 segment route");
    a_p30_timer: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (p3_low_q[1:0] == 2'h3 && !p3_high_q[4])
        |=> pad_drive_val_out[4] == $past(timer_b_pwm_output_in))
        else $error("pin 3.0 timer route");
    a_input_no_drive: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (p2_low_q[1] == 1'b0) |=> !pad_drive_en_out[0])
        else $error("input pin driven");
    a_analog_en: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (p2_low_q[7:6] == 2'h3) |=> analog_channel_en_out[3]
        && !pad_drive_en_out[3]) else $error("analog channel");

    // Covers
    c_lcd_segment_35: cover property (@(posedge clock_in) pad_drive_en_out[5]
        && p3_high_q[5]);
    c_capture: cover property (@(posedge clock_in) timer_a_capture_in_out);
    c_analog: cover property (@(posedge clock_in) analog_channel_en_out[0]);

endmodule : port2_port3_pin_mode_mux

// ==== pad_partner.sv ====
`timescale 1ns/10ps
// Pins and board around the block
module pad_partner
(
    // Clock
    input  wire logic       clock_in,
    // Pad controls from the block
    input  wire logic [9:0] drive_en_in,
    input  wire logic [9:0] drive_val_in,
    input  wire logic [9:0] pull_up_in,
    // Board side drive
    input  wire logic       ext_en_in,
    input  wire logic [9:0] ext_val_in,
    // Pin levels
    output logic      [9:0] level_out
);
    logic [9:0] last_q; // Last pin level
    // Floating pins flip, so a stale level never passes
    always_comb
        for (int i = 0; i < 10; i++)
            level_out[i] = drive_en_in[i] ? drive_val_in[i]
                : ext_en_in ? ext_val_in[i]
                : pull_up_in[i] ? 1'b1 : ~last_q[i];
    // Remember the level
    always_ff @(posedge clock_in)
        last_q <= level_out;
endmodule : pad_partner

// ==== port2_port3_pin_mode_mux_test.sv ====
`timescale 1ns/10ps
// Self-checking bench for the pin mode block
module port2_port3_pin_mode_mux_test;
    logic clk, rst_n, we, re;
    logic [7:0] addr, wd, rdata;
    logic [3:0] p2d, an;
    logic [5:0] p3d;
    logic [7:0] src; // rxd,tx,s37,s36,s35,s34,tb,ta
    logic [9:0] ext, lvl, en, val, pu;
    logic cap, rx;
    logic [31:0] seed;
    int bad_count, n_checks;
    port2_port3_pin_mode_mux dut (.clock_in(clk), .rst_n_in(rst_n),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(we),
        .reg_read_in(re), .reg_rdata_out(rdata), .port2_data_in(p2d),
        .port3_data_in(p3d), .timer_a_output_in(src[0]),
        .timer_b_pwm_output_in(src[1]), .lcd_segment_34_in(src[2]),
        .lcd_segment_35_in(src[3]), .lcd_segment_36_in(src[4]),
        .lcd_segment_37_in(src[5]), .serial_tx_in(src[6]),
        .serial_rx_drive_in(src[7]), .port2_pad_in(lvl[3:0]),
        .port3_pad_in(lvl[9:4]), .pad_drive_en_out(en),
        .pad_drive_val_out(val), .pad_pull_up_out(pu),
        .analog_channel_en_out(an), .timer_a_capture_in_out(cap),
        .serial_rx_out(rx));
    pad_partner pads (.clock_in(clk), .drive_en_in(en),
        .drive_val_in(val), .pull_up_in(pu), .ext_en_in(1'b1),
        .ext_val_in(ext), .level_out(lvl));
    // Free running clock, 100 ns
    always #50 clk = ~clk;
    // Repeatable random source
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Expected pad view; driven value masked where not driven
    function automatic logic [35:0] expect_pads(input logic [7:0] e9,
        input logic [7:0] ea, input logic [7:0] eb);
        logic [9:0] d, a, x, v, p;
        logic [1:0] m[10];
        logic [3:0] g;
        d = {p3d, p2d};
        a = {src[7:4], ea[5] ? src[3] : src[0], ea[4] ? src[2] : src[1],
             4'h0};
        for (int i = 0; i < 10; i++)
        begin
            m[i] = i < 4 ? e9[2*i+:2] : i < 8 ? eb[2*(i-4)+:2]
                 : ea[2*(i-8)+:2];
            x[i] = m[i] == 2'h2 || (m[i] == 2'h3 && i > 3);
            v[i] = x[i] & (m[i] == 2'h2 ? d[i] : a[i]);
            p[i] = m[i] == 2'h1;
            if (i < 4)
                g[i] = m[i] == 2'h3;
        end
        return {x, v, p, g, m[7] < 2 ? ext[7] : 1'b0,
                m[9] < 2 ? ext[9] : 1'b1};
    endfunction : expect_pads
    // Compare one register value
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_reg
    // Compare the pad view
    task automatic cmp_pads(input logic [35:0] exp);
        logic [35:0] got;
        got = {en, val & en, pu, an, cap, rx};
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_pads
    // One register write; strobes stay until the next call sets them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        re = 1'b0;
        we = 1'b1;
        addr = a;
        wd = d;
        @(negedge clk);
    endtask : wr
    // One register read, data checked half a cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        we = 1'b0;
        re = 1'b1;
        addr = a;
        @(negedge clk);
        cmp_reg(rdata, exp);
    endtask : rd
    // Program all fields, drive random sources, check everything
    task automatic apply(input logic [7:0] e9, input logic [7:0] ea,
        input logic [7:0] eb);
        seed = lfsr(seed);
        {p2d, p3d, src, ext} = seed[27:0];
        wr(8'hE9, e9);
        wr(8'hEA, ea);
        wr(8'hEB, eb);
        rd(8'hE9, e9);
        rd(8'hEA, ea & 8'h3F);
        rd(8'hEB, eb);
        cmp_pads(expect_pads(e9, ea, eb));
    endtask : apply
    // Verdict
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // Watchdog
    initial
    begin
        #300000;
        bad_count++;
        end_sim();
    end
    // Main sequence
    initial
    begin
        clk = 0; rst_n = 0; we = 0; re = 0; addr = 0; wd = 0;
        p2d = 0; p3d = 0; src = 0; ext = 0; seed = 32'hDE44E4EC;
        bad_count = 0; n_checks = 0;
        repeat (3) @(negedge clk);
        rst_n = 1;
        cmp_pads({30'h0, 4'h0, 1'h0, 1'h1});
        cmp_reg(rdata, 8'h00);
        @(negedge clk);
        cmp_pads(expect_pads(8'h00, 8'h00, 8'h00));
        for (int c = 0; c < 16; c++)
            apply({4{c[1:0]}}, {2'h3, c[3:2], {2{c[1:0]}}},
                  {4{c[1:0]}});
        for (int k = 0; k < 40; k++)
        begin
            seed = lfsr(seed);
            apply(seed[7:0], seed[15:8], seed[23:16]);
        end
        wr(8'hE9, 8'hA5);
        rd(8'hE9, 8'hA5);
        apply(8'hFF, 8'hFF, 8'hFF);
        wr(8'hE8, 8'h00);
        rd(8'hE8, 8'h00);
        rd(8'hE9, 8'hFF);
        rst_n = 0;
        @(negedge clk) rst_n = 1;
        cmp_pads({30'h0, 4'h0, 1'h0, 1'h1});
        cmp_reg(rdata, 8'h00);
        rd(8'hEA, 8'h00);
        rd(8'hEB, 8'h00);
        end_sim();
    end
endmodule : port2_port3_pin_mode_mux_test
